// ---- design/spt_pkg.sv ----
// shared constants for the sampling synthesizer and trigger output control
package spt_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADDR_FBDIV_PV  = 8'h3D;
  localparam logic [7:0] ADDR_FBDIV_N   = 8'h3E;
  localparam logic [7:0] ADDR_OSC_BIAS  = 8'h3F;
  localparam logic [7:0] ADDR_LANE_EMPH = 8'h48;
  localparam logic [7:0] ADDR_TRIG_CTRL = 8'h57;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_FBDIV_PV  = 8'h00;
  localparam logic [7:0] RST_FBDIV_N   = 8'h20;
  localparam logic [7:0] RST_OSC_BIAS  = 8'h4F;
  localparam logic [7:0] RST_LANE_EMPH = 8'h00;
  localparam logic [7:0] RST_TRIG_CTRL = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int V_LSB      = 0;
  localparam int P_LSB      = 2;
  localparam int N_LSB      = 0;
  localparam int BIAS_LSB   = 0;
  localparam int EMPH_LSB   = 0;
  localparam int TSEL_LSB   = 0;
  localparam int TRIG_EN_BIT = 7;

  // ****************************************
  // trigger output modes and counts
  // ****************************************
  localparam logic [2:0] TSEL_UI16  = 3'h0;
  localparam logic [2:0] TSEL_UI32  = 3'h1;
  localparam logic [2:0] TSEL_UI64  = 3'h2;
  localparam logic [2:0] TSEL_STAMP = 3'h3;
  localparam logic [5:0] TRIG_HALF_UI16 = 6'h08;
  localparam logic [5:0] TRIG_HALF_UI32 = 6'h10;
  localparam logic [5:0] TRIG_HALF_UI64 = 6'h20;

  // divide ratios; zero stops the stage
  localparam logic [5:0] RATIO_STOP = 6'h00;
  localparam logic [5:0] RATIO_1    = 6'h01;
  localparam logic [5:0] RATIO_2    = 6'h02;
  localparam logic [5:0] RATIO_3    = 6'h03;
  localparam logic [5:0] RATIO_4    = 6'h04;
  localparam logic [5:0] RATIO_5    = 6'h05;

endpackage : spt_pkg

// ---- design/spt_tick_div.sv ----
// programmable tick divider: one output tick per ratio input ticks
`timescale 1ns/1ps
module spt_tick_div #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         clr,
  input  wire logic         tick,
  input  wire logic [W-1:0] ratio,
  output logic              out_tick
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         last;

  // ratio zero never matches, so a stopped stage stays silent
  assign last     = (ratio != '0) && (cnt == ratio - W'(1));
  assign out_tick = tick && last && !clr;

  always_comb begin
    next_cnt = cnt;
    if (clr) begin
      next_cnt = '0;
    end else if (tick) begin
      next_cnt = last ? '0 : cnt + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule : spt_tick_div

// ---- design/spt_ctrl.sv ----
// synthesizer feedback dividers, lane emphasis and trigger output control
`timescale 1ns/1ps
module spt_ctrl
  import spt_pkg::*;
#(
  parameter int LANES = 8
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               reg_write,
  input  wire logic               reg_read,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  output logic      [7:0]         reg_rdata,
  output logic                    reg_rvalid,
  input  wire logic               synth_hold_in_reset,
  input  wire logic               vco_tick,
  input  wire logic               ui_tick,
  input  wire logic               serializer_reinit,
  input  wire logic               timestamp_input,
  output logic                    sample_tick,
  output logic                    pfd_fb_tick,
  output logic                    trigger_out_pin,
  output logic [6:0]              oscillator_bias_level,
  output logic [LANES*4-1:0]      lane_preemphasis
);

  // ****************************************
  // register file
  // ****************************************
  logic [7:0] fbdiv_pv, fbdiv_n, osc_bias, lane_emph, trig_ctrl;
  logic [7:0] next_fbdiv_pv, next_fbdiv_n, next_osc_bias, next_lane_emph, next_trig_ctrl;
  logic [7:0] next_rdata;

  always_comb begin
    next_fbdiv_pv  = fbdiv_pv;
    next_fbdiv_n   = fbdiv_n;
    next_osc_bias  = osc_bias;
    next_lane_emph = lane_emph;
    next_trig_ctrl = trig_ctrl;
    if (reg_write) begin
      unique case (reg_addr)
        ADDR_FBDIV_PV:  next_fbdiv_pv  = reg_wdata;
        ADDR_FBDIV_N:   next_fbdiv_n   = reg_wdata;
        ADDR_OSC_BIAS:  next_osc_bias  = reg_wdata;
        ADDR_LANE_EMPH: next_lane_emph = reg_wdata;
        ADDR_TRIG_CTRL: next_trig_ctrl = reg_wdata;
        default:        next_fbdiv_pv  = fbdiv_pv;
      endcase
    end
    // unmapped reads answer zero
    unique case (reg_addr)
      ADDR_FBDIV_PV:  next_rdata = fbdiv_pv;
      ADDR_FBDIV_N:   next_rdata = fbdiv_n;
      ADDR_OSC_BIAS:  next_rdata = osc_bias;
      ADDR_LANE_EMPH: next_rdata = lane_emph;
      ADDR_TRIG_CTRL: next_rdata = trig_ctrl;
      default:        next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fbdiv_pv   <= RST_FBDIV_PV;
      fbdiv_n    <= RST_FBDIV_N;
      osc_bias   <= RST_OSC_BIAS;
      lane_emph  <= RST_LANE_EMPH;
      trig_ctrl  <= RST_TRIG_CTRL;
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      fbdiv_pv   <= next_fbdiv_pv;
      fbdiv_n    <= next_fbdiv_n;
      osc_bias   <= next_osc_bias;
      lane_emph  <= next_lane_emph;
      trig_ctrl  <= next_trig_ctrl;
      reg_rdata  <= reg_read ? next_rdata : reg_rdata;
      reg_rvalid <= reg_read;
    end
  end

  // ****************************************
  // feedback divider chain
  // ****************************************
  logic [1:0] v_code, p_code;
  logic [5:0] v_ratio, p_ratio, n_ratio;
  logic       v_tick, p_tick, n_tick;

  assign v_code  = fbdiv_pv[V_LSB +: 2];
  assign p_code  = fbdiv_pv[P_LSB +: 2];
  assign n_ratio = fbdiv_n[N_LSB +: 6];

  // reserved codes stop the stage rather than guess a ratio
  always_comb begin
    unique case (v_code)
      2'h0:    v_ratio = RATIO_5;
      2'h1:    v_ratio = RATIO_4;
      2'h2:    v_ratio = RATIO_3;
      default: v_ratio = RATIO_STOP;
    endcase
    unique case (p_code)
      2'h0:    p_ratio = RATIO_1;
      2'h1:    p_ratio = RATIO_2;
      2'h2:    p_ratio = RATIO_4;
      default: p_ratio = RATIO_STOP;
    endcase
  end

  // ratios are only stable while held in reset, so the chain clears there
  spt_tick_div #(.W(6)) u_vdiv (
    .clk(clk), .rstn(rstn), .clr(synth_hold_in_reset), .tick(vco_tick),
    .ratio(v_ratio), .out_tick(v_tick)
  );
  spt_tick_div #(.W(6)) u_pdiv (
    .clk(clk), .rstn(rstn), .clr(synth_hold_in_reset), .tick(v_tick),
    .ratio(p_ratio), .out_tick(p_tick)
  );
  spt_tick_div #(.W(6)) u_ndiv (
    .clk(clk), .rstn(rstn), .clr(synth_hold_in_reset), .tick(p_tick),
    .ratio(n_ratio), .out_tick(n_tick)
  );

  // ****************************************
  // trigger output
  // ****************************************
  logic       trig_en, trig_tick, trig_clr, ts_s1, ts_s2, next_trig;
  logic [2:0] trig_sel;
  logic [5:0] trig_half;

  assign trig_en  = trig_ctrl[TRIG_EN_BIT];
  assign trig_sel = trig_ctrl[TSEL_LSB +: 3];

  always_comb begin
    unique case (trig_sel)
      TSEL_UI16: trig_half = TRIG_HALF_UI16;
      TSEL_UI32: trig_half = TRIG_HALF_UI32;
      TSEL_UI64: trig_half = TRIG_HALF_UI64;
      default:   trig_half = RATIO_STOP;
    endcase
  end

  assign trig_clr = !trig_en || serializer_reinit;

  spt_tick_div #(.W(6)) u_tdiv (
    .clk(clk), .rstn(rstn), .clr(trig_clr), .tick(ui_tick),
    .ratio(trig_half), .out_tick(trig_tick)
  );

  always_comb begin
    next_trig = trigger_out_pin;
    if (!trig_en) begin
      next_trig = 1'b0;
    end else if (trig_sel == TSEL_STAMP) begin
      next_trig = ts_s2;
    end else if (trig_sel > TSEL_STAMP) begin
      next_trig = 1'b0;
    end else if (serializer_reinit) begin
      next_trig = 1'b0;
    end else if (trig_tick) begin
      next_trig = !trigger_out_pin;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ts_s1                 <= 1'b0;
      ts_s2                 <= 1'b0;
      trigger_out_pin       <= 1'b0;
      sample_tick           <= 1'b0;
      pfd_fb_tick           <= 1'b0;
      oscillator_bias_level <= RST_OSC_BIAS[6:0];
    end else begin
      ts_s1                 <= timestamp_input;
      ts_s2                 <= ts_s1;
      trigger_out_pin       <= next_trig;
      sample_tick           <= p_tick;
      pfd_fb_tick           <= n_tick;
      oscillator_bias_level <= osc_bias[BIAS_LSB +: 7];
    end
  end

  // ****************************************
  // lane emphasis fan-out
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++) begin : g_lane
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          lane_preemphasis[gi*4 +: 4] <= RST_LANE_EMPH[3:0];
        end else begin
          lane_preemphasis[gi*4 +: 4] <= lane_emph[EMPH_LSB +: 4];
        end
      end
    end
  endgenerate

  // ****************************************
  // checks
  // ****************************************
  logic [5:0] v_seen, p_seen, n_seen;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      v_seen <= '0;
      p_seen <= '0;
      n_seen <= '0;
    end else if (synth_hold_in_reset) begin
      v_seen <= '0;
      p_seen <= '0;
      n_seen <= '0;
    end else begin
      if (vco_tick) v_seen <= v_tick ? 6'h00 : v_seen + 6'h01;
      if (v_tick)   p_seen <= p_tick ? 6'h00 : p_seen + 6'h01;
      if (p_tick)   n_seen <= n_tick ? 6'h00 : n_seen + 6'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  v_ratio_a: assert property (v_tick |-> v_seen == v_ratio - 6'h01)
    else $error("first divider ratio wrong");
  p_ratio_a: assert property (p_tick |-> p_seen == p_ratio - 6'h01)
    else $error("post divider ratio wrong");
  n_ratio_a: assert property (n_tick |-> n_seen == n_ratio - 6'h01)
    else $error("N divider ratio wrong");
  n_reset_a: assert property ($rose(rstn) |-> fbdiv_n == 8'h20)
    else $error("N field reset value wrong");
  lanes_same_a: assert property (##1 lane_preemphasis == {LANES{$past(lane_emph[3:0])}})
    else $error("lane emphasis mismatch");
  trig_off_a: assert property (!trig_en |=> !trigger_out_pin)
    else $error("trigger output active while disabled");
  trig_stamp_a: assert property (trig_en && trig_sel == TSEL_STAMP |=>
    trigger_out_pin == $past(ts_s2))
    else $error("timestamp not resampled");
  trig_reinit_a: assert property (trig_en && trig_sel <= TSEL_UI64 && serializer_reinit
    |=> !trigger_out_pin)
    else $error("trigger not interrupted on reinit");

  pfd_tick_c:   cover property (n_tick);
  trig_clk_c:   cover property (trig_en && trig_sel == TSEL_UI16 && trig_tick);
  trig_stamp_c: cover property (trig_en && trig_sel == TSEL_STAMP && ts_s2);
  reinit_c:     cover property (trig_en && serializer_reinit && trigger_out_pin);

endmodule : spt_ctrl

// ---- tb/spt_ctrl_tb_top.sv ----
// self-checking bench for the synthesizer dividers and trigger output control
`timescale 1ns/1ps
module spt_ctrl_tb_top;
  import spt_pkg::*;
  logic        clk, rstn, reg_write, reg_read, hold, reinit, stamp;
  logic        vco_tick = 1'b1, ui_tick = 1'b1, tick_gap = 1'b0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        reg_rvalid, sample_tick, pfd_fb_tick, trigger_out_pin;
  logic [6:0]  bias;
  logic [31:0] emph;
  logic [7:0]  d;
  int          bad_count, num_checks, cyc, p, n, r;
  int          model [int];
  int          vdiv [4] = '{5, 4, 3, 0};
  int          pdiv [4] = '{1, 2, 4, 0};
  logic        q [$];

  spt_ctrl #(.LANES(8)) DUT (.clk(clk), .rstn(rstn), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .synth_hold_in_reset(hold), .vco_tick(vco_tick),
    .ui_tick(ui_tick), .serializer_reinit(reinit), .timestamp_input(stamp),
    .sample_tick(sample_tick), .pfd_fb_tick(pfd_fb_tick), .trigger_out_pin(trigger_out_pin),
    .oscillator_bias_level(bias), .lane_preemphasis(emph));

  // ****************************************
  // clock and hang guard
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ticks every cycle, or every other cycle while tick_gap is set
  always @(negedge clk) begin
    vco_tick = !tick_gap || !vco_tick;
    ui_tick  = vco_tick;
  end

  // whole run is near 5000 cycles; the ceiling leaves ample slack
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic chk_per(input string what, input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      bad_count++;
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_per

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_write = 1'b0;
    if (model.exists(int'(a))) model[int'(a)] = int'(v);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int k;
    logic [7:0] e;
    e = model.exists(int'(a)) ? 8'(model[int'(a)]) : 8'h00;
    @(negedge clk);
    reg_read = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_read = 1'b0;
    k = 0;
    while (reg_rvalid !== 1'b1 && k < 4) begin
      @(negedge clk);
      k++;
    end
    chk("rvalid", 32'h1, {31'h0, reg_rvalid});
    chk("rdata", {24'h0, e}, {24'h0, reg_rdata});
  endtask : rd

  function automatic logic sig(input int w);
    return (w == 0) ? sample_tick : (w == 1) ? pfd_fb_tick : trigger_out_pin;
  endfunction : sig

  // cycles between the 2nd and 3rd event; -1 when the output stays quiet
  task automatic period(input int w, output int per);
    int c, ev;
    logic prev, cur;
    per = -1;
    ev = 0;
    c = 0;
    prev = sig(w);
    for (int k = 0; k < 400 && ev < 3; k++) begin
      @(negedge clk);
      cur = sig(w);
      c++;
      if ((w == 2) ? (cur !== prev) : (cur === 1'b1)) begin
        ev++;
        if (ev == 3) per = c;
        c = 0;
      end
      prev = cur;
    end
  endtask : period

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rstn, reg_write, reg_read, reinit, stamp} = 5'h00;
    hold = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    void'($urandom(32'haea2413c));
    model[int'(ADDR_FBDIV_PV)] = 32'h00;
    model[int'(ADDR_FBDIV_N)] = 32'h20;
    model[int'(ADDR_OSC_BIAS)] = 32'h4F;
    model[int'(ADDR_LANE_EMPH)] = 32'h00;
    model[int'(ADDR_TRIG_CTRL)] = 32'h00;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    foreach (model[a]) rd(8'(a));
    rd(8'h40);
    // reserved bits written as zero
    wr(ADDR_FBDIV_N, 8'($urandom) & 8'h3F);
    wr(ADDR_LANE_EMPH, 8'($urandom) & 8'h0F);
    wr(ADDR_OSC_BIAS, 8'h4A);
    wr(8'h40, 8'($urandom));
    foreach (model[a]) rd(8'(a));
    rd(8'h40);
    chk("bias", 32'h4A, {25'h0, bias});
    d = 8'(model[int'(ADDR_LANE_EMPH)]);
    chk("lanes", {8{d[3:0]}}, emph);
    for (int v = 0; v < 4; v++) begin
      for (int pc = 0; pc < 4; pc++) begin
        n = (v == 1 && pc == 1) ? 0 : int'($urandom_range(4, 1));
        @(negedge clk);
        hold = 1'b1;
        wr(ADDR_FBDIV_PV, {4'h0, 2'(pc), 2'(v)});
        wr(ADDR_FBDIV_N, 8'(n));
        @(negedge clk);
        hold = 1'b0;
        period(0, p);
        r = vdiv[v] * pdiv[pc];
        chk_per("sample period", (r == 0) ? -1 : r, p);
        if (r != 0) begin
          period(1, p);
          chk_per("feedback period", (n == 0) ? -1 : n * r, p);
        end
      end
    end
    // gapped ticks: dividers must count ticks, not clock cycles
    tick_gap = 1'b1;
    @(negedge clk);
    hold = 1'b1;
    wr(ADDR_FBDIV_PV, 8'h00);
    @(negedge clk);
    hold = 1'b0;
    period(0, p);
    chk_per("gapped sample period", 2 * vdiv[0] * pdiv[0], p);
    wr(ADDR_TRIG_CTRL, 8'h80);
    period(2, p);
    chk_per("gapped trigger half period", 2 * 8, p);
    wr(ADDR_TRIG_CTRL, 8'h00);
    tick_gap = 1'b0;
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_TRIG_CTRL, 8'(m));
      wr(ADDR_TRIG_CTRL, 8'h80 | 8'(m));
      period(2, p);
      chk_per("trigger half period", 8 << m, p);
    end
    wr(ADDR_TRIG_CTRL, 8'h00);
    repeat (3) @(negedge clk);
    chk("disabled pin", 32'h0, {31'h0, trigger_out_pin});
    wr(ADDR_TRIG_CTRL, 8'h04);
    wr(ADDR_TRIG_CTRL, 8'h84);
    period(2, p);
    chk_per("reserved mode", -1, p);
    wr(ADDR_TRIG_CTRL, 8'h04);
    wr(ADDR_TRIG_CTRL, 8'h00);
    wr(ADDR_TRIG_CTRL, 8'h80);
    repeat (12) @(negedge clk);
    reinit = 1'b1;
    repeat (2) @(negedge clk);
    chk("pin in reinit", 32'h0, {31'h0, trigger_out_pin});
    reinit = 1'b0;
    wr(ADDR_TRIG_CTRL, 8'h00);
    wr(ADDR_TRIG_CTRL, 8'h03);
    wr(ADDR_TRIG_CTRL, 8'h83);
    // timestamp mode: pin trails the input by the 2-flop sync plus output flop
    for (int k = 0; k < 40; k++) begin
      @(negedge clk);
      if (q.size() == 3) begin
        chk("stamp pin", {31'h0, q.pop_front()}, {31'h0, trigger_out_pin});
      end
      stamp = 1'($urandom);
      q.push_back(stamp);
    end
    give_verdict();
  end
endmodule : spt_ctrl_tb_top
